// ===== logic/mtcs_consts.vh
// Purpose: constants of the time-code sync and machine-control front end
// Assumes: 125 MHz system clock, byte addressed register port
// Notes: definitions only
`ifndef MTCS_CONSTS_VH
`define MTCS_CONSTS_VH

// ************************************************
// Register byte offsets
// ************************************************
`define MTCS_OFS_CFG 8'h00
`define MTCS_OFS_UNIT 8'h04
`define MTCS_OFS_TIME 8'h08
`define MTCS_OFS_STAT 8'h0C

// ************************************************
// Configuration fields
// ************************************************
`define MTCS_CFG_RATE_LSB 0
`define MTCS_CFG_SRC_BIT 3
`define MTCS_CFG_SYNC_LSB 4
`define MTCS_CFG_ROLE_LSB 6
`define MTCS_CFG_THRU_BIT 8
`define MTCS_CFG_SEND_BIT 9
`define MTCS_CFG_RECV_BIT 10
`define MTCS_CFG_MIX_LSB 11
`define MTCS_CFG_RST 13'h0000
`define MTCS_UNIT_RST 6'h11
`define MTCS_UNIT_MIN 6'h01
`define MTCS_UNIT_MAX 6'h20

// ************************************************
// Time field positions
// ************************************************
`define MTCS_TIME_HH_LSB 0
`define MTCS_TIME_MM_LSB 8
`define MTCS_TIME_SS_LSB 16
`define MTCS_TIME_FF_LSB 24

// ************************************************
// Encodings
// ************************************************
`define MTCS_RATE_30 3'h0
`define MTCS_NTSC_RATE_CONTINUOUS 3'h1
`define MTCS_NTSC_RATE_SKIPPING 3'h2
`define MTCS_RATE_25 3'h3
`define MTCS_RATE_24 3'h4
`define MTCS_SYNC_OFF 2'h0
`define MTCS_SYNC_MTC 2'h1
`define MTCS_SYNC_TEMPO 2'h2
`define MTCS_SYNC_TRACK 2'h3
`define MTCS_ROLE_OFF 2'h0
`define MTCS_ROLE_MASTER 2'h1
`define MTCS_ROLE_SLAVE 2'h2
`define MTCS_MIX_OFF 2'h0
`define MTCS_MIX_CC 2'h1
`define MTCS_MIX_EXCL 2'h2

// ************************************************
// Message bytes
// ************************************************
`define MTCS_B_SYX 8'hF0
`define MTCS_B_EOX 8'hF7
`define MTCS_B_QF 8'hF1
`define MTCS_B_CLK 8'hF8
`define MTCS_B_RT 8'h7F
`define MTCS_B_MCMD 8'h06

// ************************************************
// Timing: quarter-frame periods in ns, clock period
// ************************************************
`define MTCS_CLK_NS 8
`define MTCS_QTR_NS_30 8333333
`define MTCS_QTR_NS_2997 8341667
`define MTCS_QTR_NS_25 10000000
`define MTCS_QTR_NS_24 10416667

`endif

// ===== logic/mtcs_core.v
// Purpose: time-code generator, sync output and machine-control front end
// Assumes: byte streams and transport levels come from logic on I_SYS_CLK
// Notes: own messages send one byte per accepted I_TX_READY cycle; pass-through bytes leave without I_TX_READY
//
// What this block does
// - Rate setting 30 gives 30 frames per second, non-drop counting.
// - Continuous NTSC setting runs 29.97 frames per second, no skipped frames.
// - Skipping NTSC setting runs 29.97 frames per second with drop numbering.
// - Rates of 25 and 24 frames per second each have a setting.
// - Drop counting skips frames 0 and 1 each minute except tenth minutes.
// - Non-drop counting advances frames with no skips at minute boundaries.
// - A unit number from 1 to 32 is held for exclusive exchanges.
// - Exclusive messages are accepted only when their unit number matches ours.
// - Exclusive receive needs the receive switch on and play condition.
// - Machine-control role off sends and acts on no machine-control messages.
// - Master role transmits machine-control commands for transport operations.
// - Slave role receives machine-control commands and passes them to transport.
// - Pass-through resends every input byte unchanged instead of own messages.
// - Output port function resets to sending own messages.
// - Internal source times the transport from the own clock.
// - Received-code source runs transport only while valid code arrives.
// - Sync type time code sends quarter frames with internal source only; off sends no sync.
// - Tempo pulse type sends clock messages from the own tempo.
// - Stored pulse type sends clock messages replayed from the sync track.
// - Exclusive sending needs send switch on and own-message output.
// - Mixer message kind selects off, control change or exclusive.
`timescale 1ns/1ps
`include "mtcs_consts.vh"

module mtcs_core #(
	parameter [23:0] QTR_CYC_30 = `MTCS_QTR_NS_30 / `MTCS_CLK_NS,
	parameter [23:0] QTR_CYC_2997 = `MTCS_QTR_NS_2997 / `MTCS_CLK_NS,
	parameter [23:0] QTR_CYC_25 = `MTCS_QTR_NS_25 / `MTCS_CLK_NS,
	parameter [23:0] QTR_CYC_24 = `MTCS_QTR_NS_24 / `MTCS_CLK_NS
) (
	input wire I_SYS_CLK,
	input wire I_ARST_N,
	input wire [7:0] I_ADDR,
	input wire [31:0] I_WR_DATA,
	input wire I_WR,
	input wire I_RD,
	output reg [31:0] O_RD_DATA,
	input wire [7:0] I_RX_BYTE,
	input wire I_RX_VALID,
	output reg [7:0] O_TX_BYTE,
	output reg O_TX_VALID,
	input wire I_TX_READY,
	input wire I_PLAY_COND,
	input wire I_MTC_VALID,
	input wire I_EXT_FRAME,
	input wire I_TEMPO_TICK,
	input wire I_TRACK_TICK,
	input wire I_XPORT_CMD_VALID,
	input wire [7:0] I_XPORT_CMD,
	output reg O_XPORT_RUN,
	output reg O_MMC_VALID,
	output reg [7:0] O_MMC_CMD,
	output reg O_MIXER_CC_EN,
	output reg O_MIXER_EXCL_EN
);

	// ************************************************
	// Configuration registers
	// ************************************************
	reg [12:0] cfg_q;
	reg [5:0] unit_q;
	wire [2:0] rate = cfg_q[`MTCS_CFG_RATE_LSB +: 3];
	wire src_ext = cfg_q[`MTCS_CFG_SRC_BIT];
	wire [1:0] sync_sel = cfg_q[`MTCS_CFG_SYNC_LSB +: 2];
	wire [1:0] role = cfg_q[`MTCS_CFG_ROLE_LSB +: 2];
	wire thru = cfg_q[`MTCS_CFG_THRU_BIT];
	wire send_sw = cfg_q[`MTCS_CFG_SEND_BIT];
	wire recv_sw = cfg_q[`MTCS_CFG_RECV_BIT];
	wire [1:0] mix_kind = cfg_q[`MTCS_CFG_MIX_LSB +: 2];
	wire drop = (rate == `MTCS_NTSC_RATE_SKIPPING);
	// Exclusive id byte on the wire is unit number minus one
	wire [7:0] unit_id = {2'h0, unit_q - 6'h01};
	wire syx_send_ok = send_sw & ~thru;
	wire [5:0] wr_unit = I_WR_DATA[5:0];

	// ************************************************
	// Time-code counter
	// ************************************************
	reg [4:0] hh_q;
	reg [5:0] mm_q;
	reg [5:0] ss_q;
	reg [4:0] ff_q;
	reg [4:0] ff_max;
	reg [23:0] qtr_lim;
	reg [23:0] qcnt_q;
	reg [1:0] qidx_q;
	reg [2:0] piece_q;
	wire load_time = I_WR & (I_ADDR == `MTCS_OFS_TIME);
	wire run_ok = src_ext ? I_MTC_VALID : 1'b1;
	wire qtr_tick = ~src_ext & I_PLAY_COND & (qcnt_q == qtr_lim - 24'h000001);
	wire int_frame = qtr_tick & (qidx_q == 2'h3);
	wire adv = src_ext ? (I_EXT_FRAME & I_MTC_VALID & I_PLAY_COND) : int_frame;
	wire [5:0] mm_next = (mm_q == 6'd59) ? 6'h00 : mm_q + 6'h01;

	always @* begin
		ff_max = 5'd29;
		qtr_lim = QTR_CYC_30;
		case (rate)
			`MTCS_NTSC_RATE_CONTINUOUS: begin
				qtr_lim = QTR_CYC_2997;
			end
			`MTCS_NTSC_RATE_SKIPPING: begin
				qtr_lim = QTR_CYC_2997;
			end
			`MTCS_RATE_25: begin
				ff_max = 5'd24;
				qtr_lim = QTR_CYC_25;
			end
			`MTCS_RATE_24: begin
				ff_max = 5'd23;
				qtr_lim = QTR_CYC_24;
			end
			default: begin
				ff_max = 5'd29;
			end
		endcase
	end

	// Own frame timer; clears to zero outside play so position holds
	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			qcnt_q <= 24'h000000;
			qidx_q <= 2'h0;
		end else if (src_ext || !I_PLAY_COND || load_time) begin
			qcnt_q <= 24'h000000;
			qidx_q <= 2'h0;
		end else if (qtr_tick) begin
			qcnt_q <= 24'h000000;
			qidx_q <= qidx_q + 2'h1;
		end else begin
			qcnt_q <= qcnt_q + 24'h000001;
		end
	end

	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			hh_q <= 5'h00;
			mm_q <= 6'h00;
			ss_q <= 6'h00;
			ff_q <= 5'h00;
		end else if (load_time) begin
			hh_q <= I_WR_DATA[`MTCS_TIME_HH_LSB +: 5];
			mm_q <= I_WR_DATA[`MTCS_TIME_MM_LSB +: 6];
			ss_q <= I_WR_DATA[`MTCS_TIME_SS_LSB +: 6];
			ff_q <= I_WR_DATA[`MTCS_TIME_FF_LSB +: 5];
		end else if (adv) begin
			if (ff_q < ff_max) begin
				ff_q <= ff_q + 5'h01;
			end else begin
				ff_q <= 5'h00;
				if (ss_q == 6'd59) begin
					ss_q <= 6'h00;
					mm_q <= mm_next;
					if (mm_q == 6'd59) begin
						hh_q <= (hh_q == 5'd23) ? 5'h00 : hh_q + 5'h01;
					end
					if (drop && (mm_next % 6'd10) != 6'h00) begin
						ff_q <= 5'h02;
					end
				end else begin
					ss_q <= ss_q + 6'h01;
				end
			end
		end
	end

	// ************************************************
	// Transmit request latches
	// ************************************************
	localparam [1:0] K_CLK = 2'h0;
	localparam [1:0] K_QF = 2'h1;
	localparam [1:0] K_MMC = 2'h2;
	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	reg st_q;
	reg [1:0] kind_q;
	reg [2:0] idx_q;
	reg clk_pend_q;
	reg qf_pend_q;
	reg mmc_pend_q;
	reg [7:0] mmc_out_q;
	reg [7:0] cur_byte;
	reg [2:0] cur_last;
	wire pick = (st_q == ST_IDLE) & ~thru;
	wire take_clk = pick & clk_pend_q;
	wire take_qf = pick & ~clk_pend_q & qf_pend_q;
	wire take_mmc = pick & ~clk_pend_q & ~qf_pend_q & mmc_pend_q;
	wire clk_ev = ((sync_sel == `MTCS_SYNC_TEMPO) & I_TEMPO_TICK)
		| ((sync_sel == `MTCS_SYNC_TRACK) & I_TRACK_TICK);
	wire qf_ev = (sync_sel == `MTCS_SYNC_MTC) & qtr_tick;
	wire mmc_ev = I_XPORT_CMD_VALID & (role == `MTCS_ROLE_MASTER) & syx_send_ok;

	// New event beats the clear when both land in one cycle
	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			clk_pend_q <= 1'b0;
			qf_pend_q <= 1'b0;
			mmc_pend_q <= 1'b0;
			mmc_out_q <= 8'h00;
		end else begin
			clk_pend_q <= clk_ev | (clk_pend_q & ~take_clk);
			qf_pend_q <= qf_ev | (qf_pend_q & ~take_qf);
			mmc_pend_q <= mmc_ev | (mmc_pend_q & ~take_mmc);
			if (mmc_ev) begin
				mmc_out_q <= I_XPORT_CMD;
			end
		end
	end

	// ************************************************
	// Byte selection for the message in flight
	// ************************************************
	always @* begin
		cur_byte = `MTCS_B_CLK;
		cur_last = 3'h0;
		case (kind_q)
			K_QF: begin
				cur_last = 3'h1;
				if (idx_q == 3'h0) begin
					cur_byte = `MTCS_B_QF;
				end else begin
					case (piece_q)
						3'h0: cur_byte = {4'h0, ff_q[3:0]};
						3'h1: cur_byte = {4'h1, 3'h0, ff_q[4]};
						3'h2: cur_byte = {4'h2, ss_q[3:0]};
						3'h3: cur_byte = {4'h3, 2'h0, ss_q[5:4]};
						3'h4: cur_byte = {4'h4, mm_q[3:0]};
						3'h5: cur_byte = {4'h5, 2'h0, mm_q[5:4]};
						3'h6: cur_byte = {4'h6, hh_q[3:0]};
						default: cur_byte = {4'h7, 1'b0, qf_rate_code(rate), hh_q[4]};
					endcase
				end
			end
			K_MMC: begin
				cur_last = 3'h5;
				case (idx_q)
					3'h0: cur_byte = `MTCS_B_SYX;
					3'h1: cur_byte = `MTCS_B_RT;
					3'h2: cur_byte = unit_id;
					3'h3: cur_byte = `MTCS_B_MCMD;
					3'h4: cur_byte = mmc_out_q;
					default: cur_byte = `MTCS_B_EOX;
				endcase
			end
			default: begin
				cur_byte = `MTCS_B_CLK;
			end
		endcase
	end

	// Rate code carried in the last quarter-frame piece
	function [1:0] qf_rate_code;
		input [2:0] r;
		begin
			case (r)
				`MTCS_RATE_24: qf_rate_code = 2'h0;
				`MTCS_RATE_25: qf_rate_code = 2'h1;
				`MTCS_NTSC_RATE_SKIPPING: qf_rate_code = 2'h2;
				default: qf_rate_code = 2'h3;
			endcase
		end
	endfunction

	// ************************************************
	// Output sequencer
	// ************************************************
	// Thru has no buffer: input byte rate must not exceed the port rate
	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st_q <= ST_IDLE;
			kind_q <= K_CLK;
			idx_q <= 3'h0;
			piece_q <= 3'h0;
			O_TX_VALID <= 1'b0;
			O_TX_BYTE <= 8'h00;
		end else begin
			O_TX_VALID <= 1'b0;
			if (thru) begin
				st_q <= ST_IDLE;
				idx_q <= 3'h0;
				if (I_RX_VALID) begin
					O_TX_VALID <= 1'b1;
					O_TX_BYTE <= I_RX_BYTE;
				end
			end else begin
				case (st_q)
					ST_IDLE: begin
						idx_q <= 3'h0;
						if (take_clk) begin
							kind_q <= K_CLK;
							st_q <= ST_SEND;
						end else if (take_qf) begin
							kind_q <= K_QF;
							st_q <= ST_SEND;
						end else if (take_mmc) begin
							kind_q <= K_MMC;
							st_q <= ST_SEND;
						end
					end
					default: begin
						if (I_TX_READY) begin
							O_TX_VALID <= 1'b1;
							O_TX_BYTE <= cur_byte;
							idx_q <= idx_q + 3'h1;
							if (idx_q == cur_last) begin
								st_q <= ST_IDLE;
								if (kind_q == K_QF) begin
									piece_q <= piece_q + 3'h1;
								end
							end
						end
					end
				endcase
			end
		end
	end

	// ************************************************
	// Machine-control receive parser
	// ************************************************
	reg [2:0] ridx_q;
	reg rok_q;
	reg [7:0] rcmd_q;
	wire rx_gate = recv_sw & I_PLAY_COND & (role == `MTCS_ROLE_SLAVE);

	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ridx_q <= 3'h0;
			rok_q <= 1'b0;
			rcmd_q <= 8'h00;
			O_MMC_VALID <= 1'b0;
			O_MMC_CMD <= 8'h00;
		end else begin
			O_MMC_VALID <= 1'b0;
			// Real-time bytes may interleave and are skipped
			if (I_RX_VALID && I_RX_BYTE < `MTCS_B_CLK) begin
				if (I_RX_BYTE == `MTCS_B_SYX) begin
					ridx_q <= 3'h1;
					rok_q <= 1'b1;
				end else if (I_RX_BYTE == `MTCS_B_EOX) begin
					if (rok_q && ridx_q == 3'h5 && rx_gate) begin
						O_MMC_VALID <= 1'b1;
						O_MMC_CMD <= rcmd_q;
					end
					ridx_q <= 3'h0;
					rok_q <= 1'b0;
				end else if (I_RX_BYTE[7] || ridx_q == 3'h0 || ridx_q == 3'h5) begin
					ridx_q <= 3'h0;
					rok_q <= 1'b0;
				end else begin
					ridx_q <= ridx_q + 3'h1;
					case (ridx_q)
						3'h1: rok_q <= rok_q & (I_RX_BYTE == `MTCS_B_RT);
						3'h2: rok_q <= rok_q & (I_RX_BYTE == unit_id);
						3'h3: rok_q <= rok_q & (I_RX_BYTE == `MTCS_B_MCMD);
						default: rcmd_q <= I_RX_BYTE;
					endcase
				end
			end
		end
	end

	// ************************************************
	// Register port
	// ************************************************
	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cfg_q <= `MTCS_CFG_RST;
			unit_q <= `MTCS_UNIT_RST;
		end else if (I_WR) begin
			if (I_ADDR == `MTCS_OFS_CFG) begin
				cfg_q <= I_WR_DATA[12:0];
			end else if (I_ADDR == `MTCS_OFS_UNIT) begin
				// Out of range numbers are ignored
				if (wr_unit >= `MTCS_UNIT_MIN && wr_unit <= `MTCS_UNIT_MAX) begin
					unit_q <= wr_unit;
				end
			end
		end
	end

	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RD_DATA <= 32'h00000000;
		end else if (I_RD) begin
			if (I_ADDR == `MTCS_OFS_CFG) begin
				O_RD_DATA <= {19'h00000, cfg_q};
			end else if (I_ADDR == `MTCS_OFS_UNIT) begin
				O_RD_DATA <= {26'h0000000, unit_q};
			end else if (I_ADDR == `MTCS_OFS_TIME) begin
				O_RD_DATA <= {3'h0, ff_q, 2'h0, ss_q, 2'h0, mm_q, 3'h0, hh_q};
			end else if (I_ADDR == `MTCS_OFS_STAT) begin
				O_RD_DATA <= {28'h0000000, st_q, I_PLAY_COND, I_MTC_VALID, O_XPORT_RUN};
			end else begin
				O_RD_DATA <= 32'h00000000;
			end
		end else begin
			O_RD_DATA <= 32'h00000000;
		end
	end

	// ************************************************
	// Transport and mixer enables
	// ************************************************
	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_XPORT_RUN <= 1'b0;
			O_MIXER_CC_EN <= 1'b0;
			O_MIXER_EXCL_EN <= 1'b0;
		end else begin
			O_XPORT_RUN <= I_PLAY_COND & run_ok;
			O_MIXER_CC_EN <= (mix_kind == `MTCS_MIX_CC);
			O_MIXER_EXCL_EN <= (mix_kind == `MTCS_MIX_EXCL);
		end
	end

endmodule

// ===== sim/mtcs_core_properties.sv
// Purpose: port checker for the sync and machine-control front end
// Assumes: configuration and unit change only over the register port
// Notes: shadows CFG, UNIT and the last received bytes to judge gating
`timescale 1ns/1ps
`include "mtcs_consts.vh"
module mtcs_core_properties (
	input wire I_SYS_CLK,
	input wire I_ARST_N,
	input wire [7:0] I_ADDR,
	input wire [31:0] I_WR_DATA,
	input wire I_WR,
	input wire [7:0] I_RX_BYTE,
	input wire I_RX_VALID,
	input wire I_PLAY_COND,
	input wire I_MTC_VALID,
	input wire I_TEMPO_TICK,
	input wire [7:0] O_TX_BYTE,
	input wire O_TX_VALID,
	input wire O_XPORT_RUN,
	input wire O_MMC_VALID,
	input wire [7:0] O_MMC_CMD,
	input wire O_MIXER_CC_EN,
	input wire O_MIXER_EXCL_EN
);
	// ****************************************
	// Shadow state and checks
	// ****************************************
	reg [12:0] cfg_q;
	reg [5:0] unit_q;
	reg [7:0] h1_q, h2_q, h3_q, h4_q;
	always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			cfg_q <= `MTCS_CFG_RST;
			unit_q <= `MTCS_UNIT_RST;
			h1_q <= 8'h00;
			h2_q <= 8'h00;
			h3_q <= 8'h00;
			h4_q <= 8'h00;
		end else begin
			if (I_WR && I_ADDR == `MTCS_OFS_CFG)
				cfg_q <= I_WR_DATA[12:0];
			// Out-of-range unit writes are dropped
			if (I_WR && I_ADDR == `MTCS_OFS_UNIT && I_WR_DATA >= 32'h1 && I_WR_DATA <= 32'h20)
				unit_q <= I_WR_DATA[5:0];
			if (I_RX_VALID) begin
				h1_q <= I_RX_BYTE;
				h2_q <= h1_q;
				h3_q <= h2_q;
				h4_q <= h3_q;
			end
		end
	end
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_ARST_N);
	a_thru_echo: assert property (cfg_q[8] && I_RX_VALID |=> O_TX_VALID &&
		O_TX_BYTE == $past(I_RX_BYTE)) else $error("pass-through byte lost");
	a_mmc_unit_match: assert property (O_MMC_VALID |->
		h4_q == {2'h0, unit_q} - 8'h01 && O_MMC_CMD == h2_q)
		else $error("command accepted for other unit");
	a_mmc_slave_only: assert property (O_MMC_VALID |->
		$past(cfg_q[7:6]) == `MTCS_ROLE_SLAVE) else $error("command accepted outside slave");
	a_mmc_recv_gate: assert property (O_MMC_VALID |->
		$past(I_PLAY_COND) && $past(cfg_q[10])) else $error("command accepted while gated");
	a_run_follows_src: assert property ($past(I_ARST_N) |-> O_XPORT_RUN ==
		$past(I_PLAY_COND && (!cfg_q[3] || I_MTC_VALID))) else $error("run level wrong");
	a_send_gate: assert property (O_TX_VALID && O_TX_BYTE == `MTCS_B_SYX &&
		!$past(cfg_q[8]) |-> $past(cfg_q[9])) else $error("exclusive sent with switch off");
	a_tempo_pulse: assert property (I_TEMPO_TICK && cfg_q[5:4] == `MTCS_SYNC_TEMPO &&
		!cfg_q[8] |-> ##[3:200] O_TX_VALID && O_TX_BYTE == `MTCS_B_CLK)
		else $error("tempo tick not sent");
	a_mix_cc_level: assert property (cfg_q[12:11] == `MTCS_MIX_CC [*3] |->
		O_MIXER_CC_EN && !O_MIXER_EXCL_EN) else $error("mixer kind level wrong");
	c_mmc: cover property (O_MMC_VALID);
	c_qf: cover property (O_TX_VALID && O_TX_BYTE == `MTCS_B_QF);
	c_thru: cover property (cfg_q[8] && I_RX_VALID);
endmodule
bind mtcs_core mtcs_core_properties u_props (.I_SYS_CLK, .I_ARST_N, .I_ADDR, .I_WR_DATA,
	.I_WR, .I_RX_BYTE, .I_RX_VALID, .I_PLAY_COND, .I_MTC_VALID, .I_TEMPO_TICK, .O_TX_BYTE,
	.O_TX_VALID, .O_XPORT_RUN, .O_MMC_VALID, .O_MMC_CMD, .O_MIXER_CC_EN, .O_MIXER_EXCL_EN);

// ===== sim/mtcs_midi_peer.sv
// Purpose: far-end MIDI equipment: sends command frames, collects output bytes
// Assumes: one byte per clock in each direction
// Notes: slow mode raises ready only one cycle in three
`timescale 1ns/1ps
module mtcs_midi_peer (
	input wire i_clk,
	input wire [7:0] i_tx_byte,
	input wire i_tx_valid,
	output logic o_tx_ready,
	output logic [7:0] o_rx_byte,
	output logic o_rx_valid
);
	// ****************************************
	// Link behaviour
	// ****************************************
	logic slow = 1'b0;
	logic [7:0] got[$];
	logic [1:0] ph = 2'h0;
	initial begin
		o_tx_ready = 1'b1;
		o_rx_byte = 8'h00;
		o_rx_valid = 1'b0;
	end
	always @(posedge i_clk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		o_tx_ready <= !slow || ph == 2'h0;
		if (i_tx_valid === 1'b1)
			got.push_back(i_tx_byte);
	end
	// Frame carries the addressed unit less one; a wrong unit only on request
	task automatic send_cmd(input logic [5:0] unit, input logic [7:0] cmd);
		logic [7:0] f[6];
		f = '{8'hF0, 8'h7F, {2'h0, unit} - 8'h01, 8'h06, cmd, 8'hF7};
		for (int i = 0; i < 6; i++) begin
			@(posedge i_clk);
			o_rx_byte <= f[i];
			o_rx_valid <= 1'b1;
		end
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		// Idle line must not repeat the stale byte
		o_rx_byte <= ~f[5];
	endtask
endmodule

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the sync and machine-control front end
// Assumes: short quarter-frame periods so frame steps fit a short run
// Notes: configuration words are packed by the CFG field layout
`timescale 1ns/1ps
`include "mtcs_consts.vh"
module tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic play = 1'b0;
	logic mtcv = 1'b0;
	logic [3:0] pls = 4'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] xcmd = 8'h00;
	logic [31:0] wdata = 32'h0;
	wire [31:0] rdata;
	wire [7:0] rxb, txb, mcmd;
	wire rxv, txv, txr, run, mv, cce, exe;
	int n_errors = 0;
	int n_compared = 0;
	int n_mmc = 0;
	always #4 clk = ~clk;
	always @(posedge clk) if (mv === 1'b1) n_mmc <= n_mmc + 1;
	mtcs_core #(.QTR_CYC_30(24'h14), .QTR_CYC_2997(24'h16), .QTR_CYC_25(24'h18),
		.QTR_CYC_24(24'h1A)) dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
		.I_WR_DATA(wdata), .I_WR(wr), .I_RD(rd), .O_RD_DATA(rdata), .I_RX_BYTE(rxb),
		.I_RX_VALID(rxv), .O_TX_BYTE(txb), .O_TX_VALID(txv), .I_TX_READY(txr),
		.I_PLAY_COND(play), .I_MTC_VALID(mtcv), .I_EXT_FRAME(pls[0]), .I_TEMPO_TICK(pls[1]),
		.I_TRACK_TICK(pls[2]), .I_XPORT_CMD_VALID(pls[3]), .I_XPORT_CMD(xcmd),
		.O_XPORT_RUN(run), .O_MMC_VALID(mv), .O_MMC_CMD(mcmd), .O_MIXER_CC_EN(cce),
		.O_MIXER_EXCL_EN(exe));
	mtcs_midi_peer peer (.i_clk(clk), .i_tx_byte(txb), .i_tx_valid(txv), .o_tx_ready(txr),
		.o_rx_byte(rxb), .o_rx_valid(rxv));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		pls <= m;
		@(posedge clk);
		pls <= 4'h0;
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] d;
		logic [31:0] v[5] = '{32'h0, 32'h21, 32'h20, 32'h1, 32'h11};
		logic [31:0] e[5] = '{32'h11, 32'h11, 32'h20, 32'h1, 32'h11};
		rreg(`MTCS_OFS_CFG, d);
		chk(d, 32'h0, "cfg reset");
		rreg(8'h10, d);
		chk(d, 32'h0, "unmapped read");
		for (int i = 0; i < 5; i++) begin
			wreg(`MTCS_OFS_UNIT, v[i]);
			rreg(`MTCS_OFS_UNIT, d);
			chk(d, e[i], "unit number");
		end
		$display("regs done");
	endtask
	task automatic t_mmc();
		int k;
		logic [31:0] c[5] = '{32'h480, 32'h480, 32'h400, 32'h080, 32'h480};
		for (int i = 0; i < 5; i++) begin
			wreg(`MTCS_OFS_CFG, c[i]);
			play <= (i != 4);
			k = n_mmc;
			peer.send_cmd((i == 1) ? 6'h12 : 6'h11, 8'h02);
			cyc(3);
			chk(n_mmc - k, (i == 0), "command acceptance");
		end
		chk(mcmd, 8'h02, "command code");
		play <= 1'b0;
		$display("mmc receive done");
	endtask
	task automatic t_thru();
		wreg(`MTCS_OFS_CFG, 32'h340);
		cyc(20);
		peer.got.delete();
		peer.send_cmd(6'h11, 8'h05);
		xcmd <= 8'h01;
		pulse(4'h8);
		cyc(40);
		chk(peer.got.size(), 6, "thru count");
		chk(peer.got[4], 8'h05, "thru byte");
		$display("thru done");
	endtask
	task automatic t_master();
		logic [7:0] e[6] = '{8'hF0, 8'h7F, 8'h10, 8'h06, 8'h03, 8'hF7};
		logic [31:0] c[3] = '{32'h240, 32'h040, 32'h200};
		wreg(`MTCS_OFS_CFG, c[0]);
		cyc(40);
		peer.got.delete();
		peer.slow = 1'b1;
		for (int i = 0; i < 3; i++) begin
			wreg(`MTCS_OFS_CFG, c[i]);
			xcmd <= 8'h03;
			pulse(4'h8);
			cyc(60);
			chk(peer.got.size(), 6, "master count");
		end
		foreach (e[i])
			chk(peer.got[i], e[i], "master byte");
		peer.slow = 1'b0;
		$display("master done");
	endtask
	task automatic t_sync();
		logic [31:0] c[5] = '{32'h20, 32'h20, 32'h30, 32'h30, 32'h00};
		logic [3:0] m[5] = '{4'h2, 4'h4, 4'h4, 4'h2, 4'h6};
		for (int i = 0; i < 5; i++) begin
			wreg(`MTCS_OFS_CFG, c[i]);
			cyc(40);
			peer.got.delete();
			pulse(m[i]);
			cyc(20);
			chk(peer.got.size(), (i == 0 || i == 2), "clock count");
			chk((i == 0 || i == 2) ? peer.got[0] : 8'hF8, 8'hF8, "clock byte");
		end
		wreg(`MTCS_OFS_CFG, 32'h10);
		wreg(`MTCS_OFS_TIME, 32'h0);
		play <= 1'b1;
		peer.got.delete();
		cyc(170);
		play <= 1'b0;
		chk({peer.got[0], peer.got[1], peer.got[2], peer.got[3]}, 32'hF100F110, "qf");
		chk(peer.got[15], 8'h76, "qf rate code");
		$display("sync done");
	endtask
	task automatic t_time();
		logic [31:0] d;
		logic [2:0] r[7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h0};
		logic [31:0] s[7] = '{32'h1D3B0000, 32'h1D3B0000, 32'h1D3B0000, 32'h1D3B0900,
			32'h183B0000, 32'h173B0000, 32'h1D3B3B00};
		logic [31:0] e[7] = '{32'h100, 32'h100, 32'h02000100, 32'hA00, 32'h100, 32'h100,
			32'h1};
		for (int i = 0; i < 7; i++) begin
			wreg(`MTCS_OFS_CFG, {29'h0, r[i]});
			wreg(`MTCS_OFS_TIME, s[i]);
			play <= 1'b1;
			cyc(150);
			play <= 1'b0;
			rreg(`MTCS_OFS_TIME, d);
			chk(d, e[i], "frame step");
		end
		$display("time done");
	endtask
	task automatic t_src();
		logic [31:0] d;
		wreg(`MTCS_OFS_CFG, 32'h08);
		wreg(`MTCS_OFS_TIME, 32'h0);
		play <= 1'b1;
		cyc(3);
		chk(run, 1'b0, "run without code");
		mtcv <= 1'b1;
		pulse(4'h1);
		chk(run, 1'b1, "run with code");
		mtcv <= 1'b0;
		pulse(4'h1);
		rreg(`MTCS_OFS_TIME, d);
		chk(d, 32'h01000000, "ext frame");
		wreg(`MTCS_OFS_CFG, 32'h00);
		cyc(3);
		chk(run, 1'b1, "internal run");
		rreg(`MTCS_OFS_STAT, d);
		chk(d, 32'h5, "status");
		cyc(1);
		play <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			wreg(`MTCS_OFS_CFG, {19'h0, k[1:0], 11'h0});
			cyc(3);
			chk({cce, exe}, {k == 1, k == 2}, "mixer kind");
		end
		$display("source and mixer done");
	endtask
	initial begin
		cyc(8);
		arst_n <= 1'b1;
		t_regs();
		t_mmc();
		t_thru();
		t_master();
		t_sync();
		t_time();
		t_src();
		close_out();
	end
	initial begin
		cyc(30000);
		n_errors++;
		$display("[FAIL] %0t run limit reached", $time);
		close_out();
	end
endmodule
